/* hw/fhb_consts.svh */
`ifndef FHB_CONSTS_SVH
`define FHB_CONSTS_SVH
`define FHB_DATA_W 16
`define FHB_ADDR_W 23
`define FHB_HI_W 7
`define FHB_BANK_W 4
`define FHB_SECT_W 8
`define FHB_BANK_LSB 19
`define FHB_REGION_LSB 16
`define FHB_SMALL_LSB 14
`define FHB_BOT_REGION 7'h00
`define FHB_TOP_REGION 7'h7F
`define FHB_BIG_SECT_BASE 8'h03
`define FHB_TOP_SECT_BASE 8'h82
`define FHB_FIFO_DEPTH 4
`define FHB_MEM_AW 8
`define FHB_ERASED 16'hFFFF
`define FHB_CMD_RESET 16'h00F0
`define FHB_CMD_BURST 16'h00B0
`define FHB_CMD_PROG 16'h00A0
`define FHB_PIN_INIT 6'h3E
`define FHB_T_OE_NS 20
`define FHB_CLK_NS 8
`define FHB_OE_CYC ((`FHB_T_OE_NS + `FHB_CLK_NS - 1) / `FHB_CLK_NS)
`endif

/* hw/fhb_pkg.sv */
`include "fhb_consts.svh"
package fhb_pkg;
  typedef logic [`FHB_DATA_W-1:0] fhb_word_type;
  typedef logic [`FHB_ADDR_W-1:0] fhb_addr_type;
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h1,
    MODE_BURST = 2'h2
  } fhb_mode_type;
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_WAIT = 3'h2,
    PH_DRIVE = 3'h4
  } fhb_phase_type;
endpackage // fhb_pkg

/* hw/fhb_fifo_if.sv */
interface fhb_fifo_if #(parameter int WIDTH = 16);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic flush;
  modport ctl (output push_valid, push_data, pop_ready, flush, input push_ready, pop_valid, pop_data);
  modport store (input push_valid, push_data, pop_ready, flush, output push_ready, pop_valid, pop_data);
endinterface // fhb_fifo_if

/* hw/fhb_sync.sv */
module fhb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      meta_q <= INIT;
      q_out <= INIT;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule // fhb_sync

/* hw/fhb_fifo.sv */
module fhb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clock_in,
  input wire logic srst_in,
  fhb_fifo_if.store fif
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic full;
  logic empty;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign fif.push_ready = ~full;
  assign fif.pop_valid = ~empty;
  assign fif.pop_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clock_in) begin
    if (srst_in || fif.flush) begin
      wr_q <= '0;
    end else if (fif.push_valid && !full) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in || fif.flush) begin
      rd_q <= '0;
    end else if (fif.pop_ready && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (fif.push_valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= fif.push_data;
    end
  end
endmodule // fhb_fifo

/* hw/fhb_flash_bus.sv */
`include "fhb_consts.svh"
module fhb_flash_bus (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic chip_sel_n_in,
  input wire logic out_en_n_in,
  input wire logic wr_en_n_in,
  input wire logic address_valid_n_in,
  input wire logic hw_reset_n_in,
  input wire logic burst_clk_in,
  input wire logic [`FHB_HI_W-1:0] addr_high_in,
  input wire fhb_pkg::fhb_word_type muxed_addr_data_bus_in,
  output fhb_pkg::fhb_word_type muxed_addr_data_bus_out,
  output logic muxed_addr_data_bus_oe_out,
  output logic burst_mode_out,
  output logic [`FHB_BANK_W-1:0] bank_out,
  output logic [`FHB_SECT_W-1:0] sector_out,
  output logic small_sector_out
);
  import fhb_pkg::*;

  localparam int SW = `FHB_DATA_W + `FHB_HI_W + 6;
  localparam logic [2:0] OE_CYC = 3'(`FHB_OE_CYC);

  logic [SW-1:0] pin_s;
  logic [SW-1:0] pin_p;
  fhb_word_type bus_p;
  logic [`FHB_HI_W-1:0] hi_p;
  logic ce_n_s, oe_n_s, we_n_s, avd_n_s, rst_n_s, clk_s;
  logic oe_n_p, we_n_p, avd_n_p, clk_p;

  fhb_mode_type mode_q;
  fhb_phase_type phase_q;
  logic [2:0] cnt_q;
  logic drive_q;
  fhb_word_type data_q;
  fhb_addr_type addr_q;
  fhb_addr_type fetch_addr_q;
  logic fetch_on_q;
  logic prog_armed_q;
  fhb_addr_type cmd_addr_q;
  fhb_word_type cmd_data_q;
  logic [`FHB_BANK_W-1:0] bank_q;
  logic [`FHB_SECT_W-1:0] sector_q;
  logic small_q;
  fhb_word_type mem_q [2**`FHB_MEM_AW];

  logic hw_rst, sel, active;
  logic avd_rise, we_rise, oe_fall, clk_rise;
  logic async_latch, burst_latch, read_latch, addr_latch, cmd_write;
  logic burst_step, pop_hs;
  fhb_addr_type new_addr;
  logic [`FHB_HI_W-1:0] region;
  logic small_d;
  logic [`FHB_SECT_W-1:0] sect_d;

  fhb_fifo_if #(.WIDTH(`FHB_DATA_W)) fif ();

  fhb_sync #(
    .WIDTH(SW),
    .INIT({{(SW-6){1'b0}}, `FHB_PIN_INIT})
  ) u_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .d_in({muxed_addr_data_bus_in, addr_high_in, chip_sel_n_in, out_en_n_in,
           wr_en_n_in, address_valid_n_in, hw_reset_n_in, burst_clk_in}),
    .q_out(pin_s)
  );

  fhb_fifo #(
    .WIDTH(`FHB_DATA_W),
    .DEPTH(`FHB_FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .fif(fif.store)
  );

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pin_p <= {{(SW-6){1'b0}}, `FHB_PIN_INIT};
    end else begin
      pin_p <= pin_s;
    end
  end

  assign {ce_n_s, oe_n_s, we_n_s, avd_n_s, rst_n_s, clk_s} = pin_s[5:0];
  assign {bus_p, hi_p} = pin_p[SW-1:6];
  assign {oe_n_p, we_n_p, avd_n_p} = pin_p[4:2];
  assign clk_p = pin_p[0];

  assign hw_rst = srst_in | ~rst_n_s;
  assign avd_rise = avd_n_s & ~avd_n_p;
  assign we_rise = we_n_s & ~we_n_p;
  assign oe_fall = ~oe_n_s & oe_n_p;
  assign clk_rise = clk_s & ~clk_p;
  assign sel = ~hw_rst & ~ce_n_s & we_n_s;
  assign active = sel & ~oe_n_s;
  // Address seen one sample before the strobe edge
  assign new_addr = {hi_p, bus_p};

  assign async_latch = (mode_q == MODE_ASYNC) & sel & avd_rise;
  assign burst_latch = (mode_q == MODE_BURST) & sel & clk_rise & ~avd_n_s;
  assign read_latch = async_latch | burst_latch | (sel & oe_fall & ~avd_n_s & (mode_q == MODE_ASYNC));
  assign addr_latch = read_latch | (~hw_rst & ~ce_n_s & avd_rise);
  assign cmd_write = ~hw_rst & ~ce_n_s & we_rise;

  assign region = new_addr[`FHB_ADDR_W-1:`FHB_REGION_LSB];
  assign small_d = (region == `FHB_BOT_REGION) | (region == `FHB_TOP_REGION);
  always_comb begin
    if (region == `FHB_BOT_REGION) begin
      sect_d = {6'h00, new_addr[`FHB_REGION_LSB-1:`FHB_SMALL_LSB]};
    end else if (region == `FHB_TOP_REGION) begin
      sect_d = `FHB_TOP_SECT_BASE + {6'h00, new_addr[`FHB_REGION_LSB-1:`FHB_SMALL_LSB]};
    end else begin
      sect_d = `FHB_BIG_SECT_BASE + {1'b0, region};
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      addr_q <= '0;
      bank_q <= '0;
      sector_q <= '0;
      small_q <= 1'b1;
    end else if (addr_latch) begin
      addr_q <= new_addr;
      bank_q <= new_addr[`FHB_ADDR_W-1:`FHB_BANK_LSB];
      sector_q <= sect_d;
      small_q <= small_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cmd_addr_q <= '0;
      cmd_data_q <= '0;
    end else if (cmd_write) begin
      cmd_addr_q <= addr_q;
      cmd_data_q <= bus_p;
    end
  end

  always_ff @(posedge clock_in) begin
    if (hw_rst) begin
      mode_q <= MODE_ASYNC;
    end else if (cmd_write && bus_p == `FHB_CMD_RESET) begin
      mode_q <= MODE_ASYNC;
    end else if (cmd_write && bus_p == `FHB_CMD_BURST) begin
      mode_q <= MODE_BURST;
    end
  end

  always_ff @(posedge clock_in) begin
    if (hw_rst) begin
      prog_armed_q <= 1'b0;
    end else if (cmd_write) begin
      prog_armed_q <= (bus_p == `FHB_CMD_PROG) && !prog_armed_q;
    end
  end

  // Programming only clears bits, like a real cell
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      for (int i = 0; i < 2**`FHB_MEM_AW; i++) begin
        mem_q[i] <= `FHB_ERASED;
      end
    end else if (cmd_write && prog_armed_q) begin
      mem_q[addr_q[`FHB_MEM_AW-1:0]] <= mem_q[addr_q[`FHB_MEM_AW-1:0]] & bus_p;
    end
  end

  always_ff @(posedge clock_in) begin
    if (hw_rst) begin
      fetch_on_q <= 1'b0;
      fetch_addr_q <= '0;
    end else if (read_latch) begin
      fetch_on_q <= 1'b1;
      fetch_addr_q <= new_addr;
    end else if (fif.push_valid && fif.push_ready) begin
      fetch_addr_q <= fetch_addr_q + 1'b1;
      if (mode_q == MODE_ASYNC) begin
        fetch_on_q <= 1'b0;
      end
    end
  end

  assign fif.flush = hw_rst | read_latch;
  assign fif.push_valid = fetch_on_q;
  assign fif.push_data = mem_q[fetch_addr_q[`FHB_MEM_AW-1:0]];

  assign burst_step = (mode_q == MODE_BURST) & (phase_q == PH_DRIVE) & active & clk_rise & avd_n_s;
  assign fif.pop_ready = ((phase_q == PH_WAIT) & active & (cnt_q <= 3'h1)) | burst_step;
  assign pop_hs = fif.pop_ready & fif.pop_valid;

  always_ff @(posedge clock_in) begin
    if (!active) begin
      phase_q <= PH_IDLE;
      drive_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      unique case (phase_q)
        PH_IDLE: begin
          if (oe_fall) begin
            phase_q <= PH_WAIT;
            cnt_q <= OE_CYC;
          end
        end
        PH_WAIT: begin
          if (cnt_q > 3'h1) begin
            cnt_q <= cnt_q - 3'h1;
          end else if (fif.pop_valid) begin
            phase_q <= PH_DRIVE;
            drive_q <= 1'b1;
          end
        end
        PH_DRIVE: begin
          if (burst_latch) begin
            phase_q <= PH_WAIT;
            drive_q <= 1'b0;
            cnt_q <= OE_CYC;
          end
        end
        default: begin
          phase_q <= PH_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      data_q <= '0;
    end else if (pop_hs) begin
      data_q <= fif.pop_data;
    end
  end

  assign muxed_addr_data_bus_out = data_q;
  assign muxed_addr_data_bus_oe_out = drive_q;
  assign burst_mode_out = (mode_q == MODE_BURST);
  assign bank_out = bank_q;
  assign sector_out = sector_q;
  assign small_sector_out = small_q;

  a_mode_reset: assert property (@(posedge clock_in) disable iff (srst_in)
    !rst_n_s |=> mode_q == MODE_ASYNC) else $error("mode not async after reset");
  a_reset_float: assert property (@(posedge clock_in) disable iff (srst_in)
    !rst_n_s |=> !muxed_addr_data_bus_oe_out ##1 !muxed_addr_data_bus_oe_out)
    else $error("bus driven during hardware reset");
  a_deselect_float: assert property (@(posedge clock_in) disable iff (srst_in)
    ce_n_s |=> !muxed_addr_data_bus_oe_out && phase_q == PH_IDLE) else $error("bus driven while deselected");
  a_oe_float: assert property (@(posedge clock_in) disable iff (srst_in)
    oe_n_s |=> !muxed_addr_data_bus_oe_out) else $error("bus driven with output enable high");
  a_addr_capture: assert property (@(posedge clock_in) disable iff (srst_in)
    async_latch |=> addr_q == $past(new_addr) && fetch_on_q) else $error("read address not captured");
  a_access_delay: assert property (@(posedge clock_in) disable iff (srst_in)
    (active && oe_fall && phase_q == PH_IDLE) |=> !muxed_addr_data_bus_oe_out [*3])
    else $error("data driven before access time");
  a_one_word: assert property (@(posedge clock_in) disable iff (srst_in)
    (fif.push_valid && fif.push_ready && mode_q == MODE_ASYNC && !read_latch && !hw_rst) |=> !fetch_on_q)
    else $error("async read fetched more than one word");
  a_burst_step: assert property (@(posedge clock_in) disable iff (srst_in)
    (burst_step && fif.pop_valid) |=> data_q == $past(fif.pop_data) && muxed_addr_data_bus_oe_out)
    else $error("burst word not advanced");
  a_burst_start: assert property (@(posedge clock_in) disable iff (srst_in)
    burst_latch |=> addr_q == $past(new_addr)) else $error("burst start address lost");
  a_burst_abort: assert property (@(posedge clock_in) disable iff (srst_in)
    burst_latch |=> fetch_addr_q == $past(new_addr) && !fif.pop_valid) else $error("burst not restarted");
  a_cmd_latch: assert property (@(posedge clock_in) disable iff (srst_in)
    cmd_write |=> cmd_data_q == $past(bus_p) && cmd_addr_q == $past(addr_q)) else $error("command not latched");
  a_bank_decode: assert property (@(posedge clock_in) disable iff (srst_in)
    addr_latch |=> bank_out == $past(new_addr[22:19])) else $error("bank decode wrong");
  a_bottom_small: assert property (@(posedge clock_in) disable iff (srst_in)
    (addr_latch && new_addr[22:16] == 7'h00) |=> small_sector_out && sector_out == {6'h00, $past(new_addr[15:14])})
    else $error("bottom small sector wrong");
  a_top_small: assert property (@(posedge clock_in) disable iff (srst_in)
    (addr_latch && new_addr[22:16] == 7'h7F) |=> small_sector_out && sector_out == 8'h82 + {6'h00, $past(new_addr[15:14])})
    else $error("top small sector wrong");
  a_large_sector: assert property (@(posedge clock_in) disable iff (srst_in)
    (addr_latch && !small_d) |=> !small_sector_out && sector_out == 8'h03 + {1'b0, $past(region)})
    else $error("large sector wrong");
  a_cmd_mode: assert property (@(posedge clock_in) disable iff (srst_in)
    (cmd_write && bus_p == `FHB_CMD_BURST) |=> burst_mode_out) else $error("burst command ignored");
endmodule // fhb_flash_bus

/* verification/fhb_host_model.sv */
`include "fhb_consts.svh"
module fhb_host_model (
  input wire logic clock_in,
  input wire fhb_pkg::fhb_word_type dev_data_in,
  input wire logic dev_oe_in,
  output logic chip_sel_n_out,
  output logic out_en_n_out,
  output logic wr_en_n_out,
  output logic address_valid_n_out,
  output logic burst_clk_out,
  output logic [`FHB_HI_W-1:0] addr_high_out,
  output fhb_pkg::fhb_word_type bus_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import fhb_pkg::*;
  fhb_word_type drv_q;
  logic drv_on_q;
  // Released bus shows inverted last value
  assign bus_level_out = dev_oe_in ? dev_data_in : (drv_on_q ? drv_q : ~drv_q);
  initial begin
    chip_sel_n_out = 1'h1;
    out_en_n_out = 1'h1;
    wr_en_n_out = 1'h1;
    address_valid_n_out = 1'h1;
    burst_clk_out = 1'h0;
    addr_high_out = '0;
    drv_q = 16'h0000;
    drv_on_q = 1'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic pins(input logic cs, input logic oe, input logic we, input logic avd);
    chip_sel_n_out <= cs;
    out_en_n_out <= oe;
    wr_en_n_out <= we;
    address_valid_n_out <= avd;
    step(6);
  endtask
  task automatic drive(input fhb_addr_type a);
    drv_q <= a[15:0];
    addr_high_out <= a[22:16];
    drv_on_q <= 1'h1;
  endtask
  task automatic idle();
    drv_on_q <= 1'h0;
    pins(1'h1, 1'h1, 1'h1, 1'h1);
  endtask
  task automatic latch(input fhb_addr_type a, input logic steady);
    drive(a);
    pins(1'h0, 1'h1, 1'h1, 1'h0);
    pins(1'h0, 1'h1, 1'h1, ~steady);
  endtask
  task automatic read(input logic keep, output fhb_word_type w, output logic seen);
    int k;
    if (!keep)
      drv_on_q <= 1'h0;
    out_en_n_out <= 1'h0;
    seen = 1'h0;
    for (k = 0; k < 40 && !seen; k++) begin
      @(posedge clock_in);
      #1;
      seen = (dev_oe_in === 1'h1);
    end
    w = dev_data_in;
    @(posedge clock_in);
  endtask
  task automatic write(input fhb_addr_type a, input fhb_word_type d);
    latch(a, 1'h0);
    drv_q <= d;
    pins(1'h0, 1'h1, 1'h0, 1'h1);
    pins(1'h0, 1'h1, 1'h1, 1'h1);
    idle();
  endtask
  task automatic tick();
    burst_clk_out <= 1'h1;
    step(5);
    burst_clk_out <= 1'h0;
    step(5);
  endtask
  task automatic burst(input fhb_addr_type a);
    pins(1'h0, 1'h1, 1'h1, 1'h1);
    drive(a);
    pins(1'h0, 1'h1, 1'h1, 1'h0);
    tick();
    drv_on_q <= 1'h0;
    pins(1'h0, 1'h1, 1'h1, 1'h1);
  endtask
endmodule // fhb_host_model

/* verification/tb.sv */
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fhb_pkg::*;
  logic clock_in = 1'h0;
  logic srst_in = 1'h1;
  logic hw_reset_n = 1'h1;
  logic cs_n, oe_n, we_n, avd_n, bclk, doe, bmode, small_sect;
  logic [6:0] hi;
  logic [3:0] bank;
  logic [7:0] sect;
  fhb_word_type bus_lvl, dout, w;
  logic seen;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  always #4 clock_in = ~clock_in;
  fhb_host_model h (.clock_in(clock_in), .dev_data_in(dout), .dev_oe_in(doe), .chip_sel_n_out(cs_n),
    .out_en_n_out(oe_n), .wr_en_n_out(we_n), .address_valid_n_out(avd_n), .burst_clk_out(bclk),
    .addr_high_out(hi), .bus_level_out(bus_lvl));
  fhb_flash_bus dut (.clock_in(clock_in), .srst_in(srst_in), .chip_sel_n_in(cs_n), .out_en_n_in(oe_n),
    .wr_en_n_in(we_n), .address_valid_n_in(avd_n), .hw_reset_n_in(hw_reset_n), .burst_clk_in(bclk),
    .addr_high_in(hi), .muxed_addr_data_bus_in(bus_lvl), .muxed_addr_data_bus_out(dout),
    .muxed_addr_data_bus_oe_out(doe), .burst_mode_out(bmode), .bank_out(bank), .sector_out(sect),
    .small_sector_out(small_sect));
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] exp_sect(input fhb_addr_type a);
    if (a[22:16] == 7'h00)
      return {6'h00, a[15:14]};
    if (a[22:16] == 7'h7F)
      return 8'h82 + a[15:14];
    return 8'h03 + a[22:16];
  endfunction
  task automatic t_reset();
    `CHK("oe", 1'h0, doe)
    `CHK("mode", 1'h0, bmode)
    `CHK("small", 1'h1, small_sect)
    $display("test reset done");
  endtask
  task automatic t_map();
    fhb_addr_type tbl [7] = '{23'h000000, 23'h00C000, 23'h010000, 23'h3F8000, 23'h7EFFFF, 23'h7F0000,
      23'h7FC000};
    foreach (tbl[i]) begin
      h.latch(tbl[i], 1'h0);
      `CHK("bank", tbl[i][22:19], bank)
      `CHK("sector", exp_sect(tbl[i]), sect)
      `CHK("small", (tbl[i][22:16] == 7'h00 || tbl[i][22:16] == 7'h7F), small_sect)
      `CHK("floating", 1'h0, doe)
      h.read(1'h0, w, seen);
      `CHK("ready", 1'h1, seen)
      `CHK("erased", 16'hFFFF, w)
      h.idle();
    end
    $display("test map done");
  endtask
  task automatic t_prog();
    fhb_addr_type a;
    for (int i = 0; i < 3; i++) begin
      a = 23'h000010 + 23'(i);
      h.write(a, 16'h00A0);
      h.write(a, 16'hA5A0 + 16'(i));
      h.latch(a, 1'h0);
      `CHK("addr", 1'h0, doe)
      h.read(1'h0, w, seen);
      `CHK("prog", 16'hA5A0 + 16'(i), w)
      h.idle();
    end
    h.latch(23'h000011, 1'h1);
    h.read(1'h1, w, seen);
    `CHK("steady", 16'hA5A1, w)
    h.idle();
    $display("test program done");
  endtask
  task automatic t_burst();
    h.write(23'h000000, 16'h00B0);
    `CHK("mode", 1'h1, bmode)
    h.burst(23'h000010);
    h.read(1'h0, w, seen);
    `CHK("first", 16'hA5A0, w)
    for (int k = 1; k < 3; k++) begin
      h.tick();
      `CHK("next", 16'hA5A0 + 16'(k), dout)
    end
    h.burst(23'h000011);
    h.read(1'h0, w, seen);
    `CHK("restart", 16'hA5A1, w)
    h.pins(1'h1, 1'h0, 1'h1, 1'h1);
    `CHK("deselect", 1'h0, doe)
    h.burst(23'h000010);
    h.read(1'h0, w, seen);
    hw_reset_n <= 1'h0;
    h.step(6);
    `CHK("hwreset", 1'h0, doe)
    `CHK("async", 1'h0, bmode)
    hw_reset_n <= 1'h1;
    h.idle();
    $display("test burst done");
  endtask
  task automatic t_cmd_reset();
    h.write(23'h000000, 16'h00B0);
    `CHK("mode", 1'h1, bmode)
    h.write(23'h000000, 16'h00F0);
    `CHK("mode", 1'h0, bmode)
    $display("test command reset done");
  endtask
  initial begin
    repeat (12) @(posedge clock_in);
    srst_in <= 1'h0;
    h.step(2);
    t_reset();
    t_map();
    t_prog();
    t_burst();
    t_cmd_reset();
    tally_and_finish();
  end
endmodule // tb
